/* File: logic/timer8_wave.sv */
// Eight-bit timer with compare output units and port pin override.
//
// What this block does
// - Waveform output states clear to zero on system reset.
// - Nonzero action select drives pin from waveform state, not port register.
// - Pin direction stays with direction register; software sets output first.
// - Pin override depends only on action select, not on mode.
// - Action select zero leaves output state unchanged on matches, every mode.
// - New action select acts at next match; force strobe acts now, non-PWM.
// - Counting depends only on mode field, never on action select.
// - PWM: select picks polarity; non-PWM: select sets, clears or toggles.
// - Mode zero increments and wraps 0xFF to 0x00; count writable anytime.
// - Normal mode sets overflow flag as count becomes zero; only sets.
// - Overflow flag clears automatically when its interrupt is executed.
// - Mode two clears count when equal to compare value A.
// - Clear-on-match mode sets compare A flag at each top reach.
// - No compare A buffering there; value below count means wrap first.
// - Toggle select on channel A toggles every match; zero gives half rate.
// - Clear-on-match mode sets overflow flag on wrap from maximum to zero.
// - Modes three and seven are fast PWM; top is 0xFF or compare A.
// - Fast PWM non-inverting clears on match, sets at bottom; inverting opposite.
// - Fast PWM counts to top, then clears at next timer tick.
// - Fast PWM select two is non-inverted, three inverted.
// - Fast PWM sets overflow flag each time count passes from top to bottom.
// - PWM toggle works on channel A only with mode high bit set.
// - Compare equality sets its flag on the next timer tick.
module timer8_wave (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Timer clock enable from the prescaler or external source.
    input wire logic timer_tick,
    // Interrupt executed acknowledges.
    input wire logic ovf_int_ack,
    input wire logic cmp_a_int_ack,
    input wire logic cmp_b_int_ack,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Port pins of the two compare outputs.
    output logic pin_a_out,
    output logic pin_a_oe_n,
    output logic pin_b_out,
    output logic pin_b_oe_n,
    // Status.
    output logic [7:0] count_value,
    output logic overflow_flag,
    output logic compare_a_flag,
    output logic compare_b_flag
);

    logic [7:0] timer_ctrl_a_reg;
    logic timer_ctrl_b_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] compare_value_a_reg;
    logic [7:0] compare_value_b_reg;
    logic [7:0] cmp_a_buf_reg;
    logic [7:0] cmp_b_buf_reg;
    logic ovf_reg;
    logic ovf_next;
    logic cmp_a_flag_reg;
    logic cmp_a_flag_next;
    logic cmp_b_flag_reg;
    logic cmp_b_flag_next;
    logic [1:0] port_out_reg;
    logic [1:0] port_dir_reg;
    logic block_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic pin_a_reg;
    logic pin_b_reg;
    logic oe_a_n_reg;
    logic oe_b_n_reg;

    // Register decode.
    wire wr_ctrl_a = reg_wr && (reg_addr == timer8_pkg::OFS_CTRL_A);
    wire wr_ctrl_b = reg_wr && (reg_addr == timer8_pkg::OFS_CTRL_B);
    wire wr_ctrl_c = reg_wr && (reg_addr == timer8_pkg::OFS_CTRL_C);
    wire wr_count = reg_wr && (reg_addr == timer8_pkg::OFS_COUNT);
    wire wr_cmp_a = reg_wr && (reg_addr == timer8_pkg::OFS_CMP_A);
    wire wr_cmp_b = reg_wr && (reg_addr == timer8_pkg::OFS_CMP_B);
    wire wr_flags = reg_wr && (reg_addr == timer8_pkg::OFS_FLAGS);
    wire wr_port_out = reg_wr && (reg_addr == timer8_pkg::OFS_PORT_OUT);
    wire wr_port_dir = reg_wr && (reg_addr == timer8_pkg::OFS_PORT_DIR);

    // Mode field assembled from two registers.
    wire [2:0] wave_gen_mode_sel = {timer_ctrl_b_reg,
        timer_ctrl_a_reg[timer8_pkg::CTRL_A_MODE_HI:timer8_pkg::CTRL_A_MODE_LO]};
    wire [1:0] out_action_sel_a =
        timer_ctrl_a_reg[timer8_pkg::CTRL_A_SEL_A_HI:timer8_pkg::CTRL_A_SEL_A_LO];
    wire [1:0] out_action_sel_b =
        timer_ctrl_a_reg[timer8_pkg::CTRL_A_SEL_B_HI:timer8_pkg::CTRL_A_SEL_B_LO];

    // Counting follows only the mode field.
    wire mode_normal = wave_gen_mode_sel == timer8_pkg::MODE_NORMAL;
    wire clear_on_match_mode = wave_gen_mode_sel == timer8_pkg::MODE_CLEAR_ON_MATCH;
    // Two fast PWM codes with different tops.
    wire mode_fpwm_cmp = wave_gen_mode_sel == timer8_pkg::MODE_FAST_PWM_CMP;
    wire mode_fast_pwm = (wave_gen_mode_sel == timer8_pkg::MODE_FAST_PWM_MAX) || mode_fpwm_cmp;
    wire mode_non_pwm = mode_normal || clear_on_match_mode;
    wire mode_known = mode_non_pwm || mode_fast_pwm;

    wire [7:0] top_value = mode_fpwm_cmp ? compare_value_a_reg : timer8_pkg::COUNT_MAX;
    wire at_top = count_reg == top_value;
    wire at_max = count_reg == timer8_pkg::COUNT_MAX;
    wire eq_a = count_reg == compare_value_a_reg;
    wire eq_b = count_reg == compare_value_b_reg;

    // Equality seen during a tick period counts at the next tick.
    // A count write blocks matches at the following tick, so a preload never fires.
    wire match_a = timer_tick && eq_a && !block_reg && mode_known;
    wire match_b = timer_tick && eq_b && !block_reg && mode_known;
    // Counter leaves top for bottom on the tick after reaching it.
    wire bottom_evt = timer_tick && mode_fast_pwm && at_top && !wr_count;

    wire force_a = wr_ctrl_c && reg_wdata[timer8_pkg::CTRL_C_FORCE_A];
    wire force_b = wr_ctrl_c && reg_wdata[timer8_pkg::CTRL_C_FORCE_B];

    // Normal and clear-on-match overflow on wrap from maximum.
    // Same wrap rule in clear-on-match mode.
    // Fast PWM overflow each time count leaves top for bottom.
    wire ovf_set = timer_tick && !wr_count
        && ((mode_non_pwm && at_max) || (mode_fast_pwm && at_top));

    // Count moves only on a timer tick or a count write.
    always_comb begin
        count_next = count_reg;
        if (wr_count) begin
            count_next = reg_wdata;
        end else if (timer_tick) begin
            if (mode_normal) begin
                count_next = count_reg + timer8_pkg::COUNT_STEP;
            end else if (clear_on_match_mode) begin
                // Only equality clears, so a low top wraps first.
                count_next = eq_a ? timer8_pkg::COUNT_BOTTOM
                    : count_reg + timer8_pkg::COUNT_STEP;
            end else if (mode_fast_pwm) begin
                count_next = at_top ? timer8_pkg::COUNT_BOTTOM
                    : count_reg + timer8_pkg::COUNT_STEP;
            end
        end
    end

    // Flags: a hardware set wins over a clear in the same cycle.
    always_comb begin
        ovf_next = ovf_reg;
        if (ovf_int_ack || (wr_flags && reg_wdata[timer8_pkg::FLAG_OVF])) begin
            ovf_next = 1'b0;
        end
        if (ovf_set) begin
            ovf_next = 1'b1;
        end
        cmp_a_flag_next = cmp_a_flag_reg;
        if (cmp_a_int_ack || (wr_flags && reg_wdata[timer8_pkg::FLAG_CMP_A])) begin
            cmp_a_flag_next = 1'b0;
        end
        // Compare A flag on every compare A match, in every known mode.
        if (match_a) begin
            cmp_a_flag_next = 1'b1;
        end
        cmp_b_flag_next = cmp_b_flag_reg;
        if (cmp_b_int_ack || (wr_flags && reg_wdata[timer8_pkg::FLAG_CMP_B])) begin
            cmp_b_flag_next = 1'b0;
        end
        if (match_b) begin
            cmp_b_flag_next = 1'b1;
        end
    end

    // Read data is shown only in the cycle after the read strobe.
    always_comb begin
        rdata_next = timer8_pkg::RST_BYTE;
        if (reg_rd) begin
            unique case (reg_addr)
                timer8_pkg::OFS_CTRL_A: rdata_next = timer_ctrl_a_reg;
                timer8_pkg::OFS_CTRL_B: begin
                    rdata_next[timer8_pkg::CTRL_B_MODE_HI_BIT] = timer_ctrl_b_reg;
                end
                timer8_pkg::OFS_COUNT: rdata_next = count_reg;
                timer8_pkg::OFS_CMP_A: rdata_next = cmp_a_buf_reg;
                timer8_pkg::OFS_CMP_B: rdata_next = cmp_b_buf_reg;
                timer8_pkg::OFS_FLAGS: begin
                    rdata_next[timer8_pkg::FLAG_OVF] = ovf_reg;
                    rdata_next[timer8_pkg::FLAG_CMP_A] = cmp_a_flag_reg;
                    rdata_next[timer8_pkg::FLAG_CMP_B] = cmp_b_flag_reg;
                end
                timer8_pkg::OFS_PORT_OUT: rdata_next[1:0] = port_out_reg;
                timer8_pkg::OFS_PORT_DIR: rdata_next[1:0] = port_dir_reg;
                default: rdata_next = timer8_pkg::RST_BYTE;
            endcase
        end
    end

    // Control and port registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_ctrl_a_reg <= timer8_pkg::RST_BYTE;
            timer_ctrl_b_reg <= 1'b0;
            port_out_reg <= timer8_pkg::RST_PORT;
            port_dir_reg <= timer8_pkg::RST_PORT;
        end else begin
            if (wr_ctrl_a) begin
                timer_ctrl_a_reg <= reg_wdata;
            end
            if (wr_ctrl_b) begin
                timer_ctrl_b_reg <= reg_wdata[timer8_pkg::CTRL_B_MODE_HI_BIT];
            end
            if (wr_port_out) begin
                port_out_reg <= reg_wdata[1:0];
            end
            if (wr_port_dir) begin
                port_dir_reg <= reg_wdata[1:0];
            end
        end
    end

    // Counter, match blocking and flags.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= timer8_pkg::RST_BYTE;
            block_reg <= 1'b0;
            ovf_reg <= 1'b0;
            cmp_a_flag_reg <= 1'b0;
            cmp_b_flag_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            if (wr_count) begin
                block_reg <= 1'b1;
            end else if (timer_tick) begin
                block_reg <= 1'b0;
            end
            ovf_reg <= ovf_next;
            cmp_a_flag_reg <= cmp_a_flag_next;
            cmp_b_flag_reg <= cmp_b_flag_next;
        end
    end

    // Compare values: direct in non-PWM modes, reloaded at bottom in fast PWM.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_a_buf_reg <= timer8_pkg::RST_BYTE;
            cmp_b_buf_reg <= timer8_pkg::RST_BYTE;
            compare_value_a_reg <= timer8_pkg::RST_BYTE;
            compare_value_b_reg <= timer8_pkg::RST_BYTE;
        end else begin
            if (wr_cmp_a) begin
                cmp_a_buf_reg <= reg_wdata;
            end
            if (wr_cmp_b) begin
                cmp_b_buf_reg <= reg_wdata;
            end
            // Unbuffered compare A outside fast PWM.
            if (wr_cmp_a && !mode_fast_pwm) begin
                compare_value_a_reg <= reg_wdata;
            end else if (bottom_evt) begin
                compare_value_a_reg <= cmp_a_buf_reg;
            end
            if (wr_cmp_b && !mode_fast_pwm) begin
                compare_value_b_reg <= reg_wdata;
            end else if (bottom_evt) begin
                compare_value_b_reg <= cmp_b_buf_reg;
            end
        end
    end

    logic wave_out_a;
    logic wave_out_b;

    // Channel A toggles on every match in clear-on-match mode.
    wave_out_channel #(
        .TOGGLE_IN_PWM(1'b1)
    ) u_chan_a (
        .clk(clk),
        .rst_n(rst_n),
        .match_evt(match_a),
        .bottom_evt(bottom_evt),
        .force_evt(force_a),
        .out_action_sel(out_action_sel_a),
        .non_pwm_mode(mode_non_pwm),
        .fast_pwm_mode(mode_fast_pwm),
        .wave_gen_mode_hi_bit(timer_ctrl_b_reg),
        .wave_out_state(wave_out_a)
    );

    wave_out_channel #(
        .TOGGLE_IN_PWM(1'b0)
    ) u_chan_b (
        .clk(clk),
        .rst_n(rst_n),
        .match_evt(match_b),
        .bottom_evt(bottom_evt),
        .force_evt(force_b),
        .out_action_sel(out_action_sel_b),
        .non_pwm_mode(mode_non_pwm),
        .fast_pwm_mode(mode_fast_pwm),
        .wave_gen_mode_hi_bit(timer_ctrl_b_reg),
        .wave_out_state(wave_out_b)
    );

    // Override picks the waveform state when selector is nonzero.
    // The mode plays no part in the override.
    wire pin_a_next = (out_action_sel_a != timer8_pkg::ACT_NONE) ? wave_out_a
        : port_out_reg[timer8_pkg::PORT_BIT_A];
    wire pin_b_next = (out_action_sel_b != timer8_pkg::ACT_NONE) ? wave_out_b
        : port_out_reg[timer8_pkg::PORT_BIT_B];

    // Pins are registered, which costs one cycle of latency but keeps them glitch free.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_a_reg <= 1'b0;
            pin_b_reg <= 1'b0;
            oe_a_n_reg <= 1'b1;
            oe_b_n_reg <= 1'b1;
            rdata_reg <= timer8_pkg::RST_BYTE;
        end else begin
            pin_a_reg <= pin_a_next;
            pin_b_reg <= pin_b_next;
            // Direction comes from the direction register alone.
            oe_a_n_reg <= ~port_dir_reg[timer8_pkg::PORT_BIT_A];
            oe_b_n_reg <= ~port_dir_reg[timer8_pkg::PORT_BIT_B];
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign pin_a_out = pin_a_reg;
    assign pin_b_out = pin_b_reg;
    assign pin_a_oe_n = oe_a_n_reg;
    assign pin_b_oe_n = oe_b_n_reg;
    assign count_value = count_reg;
    assign overflow_flag = ovf_reg;
    assign compare_a_flag = cmp_a_flag_reg;
    assign compare_b_flag = cmp_b_flag_reg;

endmodule

/* File: logic/timer8_pkg.sv */
// Package with register offsets, field positions, reset values and mode codes of the timer.
package timer8_pkg;

    // Register port geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [3:0] OFS_CTRL_A = 4'h0;
    localparam logic [3:0] OFS_CTRL_B = 4'h1;
    localparam logic [3:0] OFS_CTRL_C = 4'h2;
    localparam logic [3:0] OFS_COUNT = 4'h3;
    localparam logic [3:0] OFS_CMP_A = 4'h4;
    localparam logic [3:0] OFS_CMP_B = 4'h5;
    localparam logic [3:0] OFS_FLAGS = 4'h6;
    localparam logic [3:0] OFS_PORT_OUT = 4'h7;
    localparam logic [3:0] OFS_PORT_DIR = 4'h8;

    // Field positions in timer_ctrl_a.
    localparam int CTRL_A_SEL_A_HI = 7;
    localparam int CTRL_A_SEL_A_LO = 6;
    localparam int CTRL_A_SEL_B_HI = 5;
    localparam int CTRL_A_SEL_B_LO = 4;
    localparam int CTRL_A_MODE_HI = 1;
    localparam int CTRL_A_MODE_LO = 0;
    // Field position in timer_ctrl_b.
    localparam int CTRL_B_MODE_HI_BIT = 3;
    // Field positions in timer_ctrl_c (write-only strobes).
    localparam int CTRL_C_FORCE_A = 7;
    localparam int CTRL_C_FORCE_B = 6;
    // Field positions in the flag register.
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMP_A = 1;
    localparam int FLAG_CMP_B = 2;
    // Bit of channel A and channel B in the port registers.
    localparam int PORT_BIT_A = 0;
    localparam int PORT_BIT_B = 1;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_PORT = 2'h0;
    localparam logic RST_STATE = 1'b0;

    // Count extremes.
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_STEP = 8'h01;

    // Waveform generation mode codes.
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
    localparam logic [2:0] MODE_FAST_PWM_MAX = 3'h3;
    localparam logic [2:0] MODE_FAST_PWM_CMP = 3'h7;

    // Output action select codes.
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

endpackage

/* File: logic/wave_out_channel.sv */
// One compare output channel: the waveform output state flip-flop and its actions.
module wave_out_channel #(
    parameter bit TOGGLE_IN_PWM = 1'b0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Events from the counter and the force strobe.
    input wire logic match_evt,
    input wire logic bottom_evt,
    input wire logic force_evt,
    // Configuration.
    input wire logic [1:0] out_action_sel,
    input wire logic non_pwm_mode,
    input wire logic fast_pwm_mode,
    input wire logic wave_gen_mode_hi_bit,
    // State.
    output logic wave_out_state
);

    logic state_next;
    logic nonpwm_hit;
    logic pwm_toggle_ok;

    // Forcing acts at once in non-PWM modes.
    assign nonpwm_hit = non_pwm_mode & (match_evt | force_evt);
    // PWM toggle only on channel A with high mode bit.
    assign pwm_toggle_ok = TOGGLE_IN_PWM & wave_gen_mode_hi_bit;

    always_comb begin
        state_next = wave_out_state;
        // Action zero leaves the state alone.
        if (out_action_sel != timer8_pkg::ACT_NONE) begin
            if (nonpwm_hit) begin
                unique case (out_action_sel)
                    timer8_pkg::ACT_TOGGLE: state_next = ~wave_out_state;
                    timer8_pkg::ACT_CLEAR: state_next = 1'b0;
                    timer8_pkg::ACT_SET: state_next = 1'b1;
                    default: state_next = wave_out_state;
                endcase
            end else if (fast_pwm_mode) begin
                // Match and bottom edges; bottom wins if both.
                unique case (out_action_sel)
                    timer8_pkg::ACT_TOGGLE: begin
                        if (match_evt && pwm_toggle_ok) begin
                            state_next = ~wave_out_state;
                        end
                    end
                    timer8_pkg::ACT_CLEAR: begin
                        if (bottom_evt) begin
                            state_next = 1'b1;
                        end else if (match_evt) begin
                            state_next = 1'b0;
                        end
                    end
                    timer8_pkg::ACT_SET: begin
                        if (bottom_evt) begin
                            state_next = 1'b0;
                        end else if (match_evt) begin
                            state_next = 1'b1;
                        end
                    end
                    default: state_next = wave_out_state;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_out_state <= timer8_pkg::RST_STATE;
        end else begin
            wave_out_state <= state_next;
        end
    end

endmodule

/* File: tb/pin_load.sv */
// External load on one port pin, with a pull-up that wins while the pin is released.
module pin_load #(
    parameter bit PULL = 1'b1
) (
    // Pin as driven by the timer.
    input wire logic drv,
    input wire logic oe_n,
    // Level seen by the external circuit.
    output logic pad
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pad = oe_n ? PULL : drv;
endmodule

/* File: tb/timer8_wave_properties.sv */
// Checker of the timer ports, bound to the timer.
module timer8_wave_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Timer inputs.
    input wire logic timer_tick,
    input wire logic ovf_int_ack,
    input wire logic cmp_a_int_ack,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // Timer outputs.
    input wire logic pin_a_out,
    input wire logic pin_a_oe_n,
    input wire logic [7:0] count_value,
    input wire logic overflow_flag,
    input wire logic compare_a_flag,
    input wire logic compare_b_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic wr_cnt;
    logic wr_dir;
    logic wr_flg;
    logic wd0;
    assign wr_cnt = reg_wr && (reg_addr == timer8_pkg::OFS_COUNT);
    assign wr_dir = reg_wr && (reg_addr == timer8_pkg::OFS_PORT_DIR);
    assign wr_flg = reg_wr && (reg_addr == timer8_pkg::OFS_FLAGS);
    assign wd0 = reg_wdata[0];
    property p_cnt_wr;
        wr_cnt |=> count_value == $past(reg_wdata);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");
    // Count moves only on a tick or a write, which keeps the block synchronous.
    property p_cnt_hold;
        !timer_tick && !wr_cnt |=> $stable(count_value);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved without tick");
    property p_ovf_keep;
        overflow_flag && !ovf_int_ack && !(wr_flg && wd0) |=> overflow_flag;
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag dropped");
    property p_ovf_ack;
        ovf_int_ack && !timer_tick |=> !overflow_flag;
    endproperty
    a_ovf_ack: assert property (p_ovf_ack) else $error("overflow ack ignored");
    property p_ovf_cause;
        $rose(overflow_flag) && !$past(wr_cnt) |-> $past(timer_tick) && count_value == 8'h00;
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without wrap");
    property p_cmpa_tick;
        $rose(compare_a_flag) |-> $past(timer_tick);
    endproperty
    a_cmpa_tick: assert property (p_cmpa_tick) else $error("compare A flag off tick");
    property p_cmpb_tick;
        $rose(compare_b_flag) |-> $past(timer_tick);
    endproperty
    a_cmpb_tick: assert property (p_cmpb_tick) else $error("compare B flag off tick");
    property p_cmpa_keep;
        compare_a_flag && !cmp_a_int_ack && !(wr_flg && reg_wdata[1]) |=> compare_a_flag;
    endproperty
    a_cmpa_keep: assert property (p_cmpa_keep) else $error("compare A flag dropped");
    property p_dir;
        wr_dir ##1 !wr_dir |=> pin_a_oe_n == !$past(wd0, 2);
    endproperty
    a_dir: assert property (p_dir) else $error("pin enable not from direction");
    c_ovf: cover property ($rose(overflow_flag));
    c_cmpa: cover property ($rose(compare_a_flag));
    c_pin: cover property ($changed(pin_a_out));
endmodule

bind timer8_wave timer8_wave_checker u_timer8_wave_checker (.clk(clk), .rst_n(rst_n),
    .timer_tick(timer_tick), .ovf_int_ack(ovf_int_ack), .cmp_a_int_ack(cmp_a_int_ack),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pin_a_out(pin_a_out),
    .pin_a_oe_n(pin_a_oe_n), .count_value(count_value), .overflow_flag(overflow_flag),
    .compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag));

/* File: tb/timer8_wave_tb_top.sv */
// Self-checking bench of the timer with its two pin loads.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module timer8_wave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic timer_tick = 1'b0;
    logic [2:0] acks = 3'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, count_value;
    logic pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n, pad_a, pad_b;
    logic overflow_flag, compare_a_flag, compare_b_flag;
    int miscompares = 0;
    int cmp_count = 0;
    always #12.5 clk = ~clk;
    timer8_wave u_timer8_wave (.clk(clk), .rst_n(rst_n), .timer_tick(timer_tick),
        .ovf_int_ack(acks[0]), .cmp_a_int_ack(acks[1]), .cmp_b_int_ack(acks[2]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n),
        .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n), .count_value(count_value),
        .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
        .compare_b_flag(compare_b_flag));
    pin_load u_pin_load_a (.drv(pin_a_out), .oe_n(pin_a_oe_n), .pad(pad_a));
    pin_load u_pin_load_b (.drv(pin_b_out), .oe_n(pin_b_oe_n), .pad(pad_b));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    // Pins lag the state by one clock, so two edges let every update land.
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic tick(input int n);
        @(posedge clk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge clk);
        timer_tick <= 1'b0;
        settle;
    endtask
    task automatic ack(input logic [2:0] m);
        @(posedge clk);
        acks <= m;
        @(posedge clk);
        acks <= 3'h0;
        #1;
    endtask
    task automatic t_reset;
        `CHK(pin_a_out, 1'b0)
        `CHK(pad_a, 1'b1)
        rd(timer8_pkg::OFS_CTRL_A, 8'h00);
        wr(4'hF, 8'h5A);
        rd(4'hF, 8'h00);
    endtask
    task automatic t_normal;
        wr(timer8_pkg::OFS_PORT_OUT, 8'h02);
        wr(timer8_pkg::OFS_PORT_DIR, 8'h03);
        wr(timer8_pkg::OFS_CMP_B, 8'hFF);
        wr(timer8_pkg::OFS_COUNT, 8'hFE);
        tick(2);
        `CHK(count_value, 8'h00)
        `CHK(overflow_flag, 1'b1)
        `CHK(compare_b_flag, 1'b1)
        `CHK(pad_b, 1'b1)
        ack(3'h1);
        `CHK(overflow_flag, 1'b0)
        wr(timer8_pkg::OFS_PORT_OUT, 8'h00);
        settle;
        `CHK(pin_b_out, 1'b0)
    endtask
    task automatic t_match_clear;
        wr(timer8_pkg::OFS_CMP_A, 8'h02);
        wr(timer8_pkg::OFS_CTRL_A, 8'h42);
        wr(timer8_pkg::OFS_COUNT, 8'h00);
        tick(3);
        `CHK(count_value, 8'h00)
        `CHK(compare_a_flag, 1'b1)
        `CHK(pad_a, 1'b1)
        tick(3);
        `CHK(pad_a, 1'b0)
        ack(3'h2);
        tick(1);
        wr(timer8_pkg::OFS_CMP_A, 8'h00);
        tick(255);
        `CHK(count_value, 8'h00)
        `CHK(overflow_flag, 1'b1)
        `CHK(compare_a_flag, 1'b0)
        tick(1);
        `CHK(compare_a_flag, 1'b1)
        `CHK(pad_a, 1'b1)
        tick(1);
        `CHK(pad_a, 1'b0)
    endtask
    task automatic t_force;
        wr(timer8_pkg::OFS_CTRL_A, 8'h30);
        ack(3'h4);
        `CHK(pin_b_out, 1'b0)
        wr(timer8_pkg::OFS_CTRL_C, 8'h40);
        settle;
        `CHK(pin_b_out, 1'b1)
        `CHK(compare_b_flag, 1'b0)
        wr(timer8_pkg::OFS_CTRL_A, 8'h20);
        wr(timer8_pkg::OFS_CTRL_C, 8'h40);
        settle;
        `CHK(pin_b_out, 1'b0)
    endtask
    task automatic t_pwm;
        wr(timer8_pkg::OFS_FLAGS, 8'h07);
        wr(timer8_pkg::OFS_CMP_A, 8'h10);
        wr(timer8_pkg::OFS_CMP_B, 8'h10);
        wr(timer8_pkg::OFS_CTRL_A, 8'hB3);
        rd(timer8_pkg::OFS_CTRL_A, 8'hB3);
        wr(timer8_pkg::OFS_COUNT, 8'hFE);
        tick(2);
        `CHK(count_value, 8'h00)
        `CHK(overflow_flag, 1'b1)
        `CHK(pin_a_out, 1'b1)
        `CHK(pin_b_out, 1'b0)
        tick(17);
        `CHK(count_value, 8'h11)
        `CHK(pin_a_out, 1'b0)
        `CHK(pin_b_out, 1'b1)
        wr(timer8_pkg::OFS_CTRL_B, 8'h08);
        wr(timer8_pkg::OFS_COUNT, 8'h0E);
        wr(timer8_pkg::OFS_FLAGS, 8'h07);
        tick(3);
        `CHK(count_value, 8'h00)
        `CHK(overflow_flag, 1'b1)
        `CHK(pin_a_out, 1'b1)
        wr(timer8_pkg::OFS_CTRL_A, 8'h73);
        tick(17);
        `CHK(pin_a_out, 1'b0)
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset;
        t_normal;
        t_match_clear;
        t_force;
        t_pwm;
        wrap_up;
    end
    // A hang counts as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        wrap_up;
    end
endmodule
